// ---- cmp_pkg.sv ----
// Shared constants and carrier types for the comparator control block.
`default_nettype none
package cmp_pkg;

    // ==========================================================
    // Register map, byte offsets within the slave window
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] CTL_OFF    = 8'h00;
    localparam logic [7:0] STAT_OFF   = 8'h04;
    localparam logic [7:0] MASK_OFF   = 8'h08;
    localparam logic [7:0] PINSEL_OFF = 8'h0c;
    localparam logic [7:0] LATCH_OFF  = 8'h10;
    localparam logic [7:0] PCTL_OFF   = 8'h14;
    localparam logic [7:0] PREAD_OFF  = 8'h18;

    // ==========================================================
    // Field positions and reset values
    localparam int         CTL_ON_BIT  = 6;
    localparam int         CTL_INV_BIT = 5;
    localparam int         CTL_RES_BIT = 4;
    localparam int         CTL_HYS_BIT = 0;
    localparam logic       ON_RESET    = 1'b0;
    localparam logic       INV_RESET   = 1'b0;
    localparam logic       HYS_RESET   = 1'b1;
    localparam int         CHG_BIT     = 0;
    localparam int         SEL_IN_BIT  = 0;
    localparam int         SEL_OUT_BIT = 1;

    // ==========================================================
    // Shared pins: positive input, negative input, result output
    localparam int         NPINS       = 3;
    localparam int         PIN_POS     = 0;
    localparam int         PIN_NEG     = 1;
    localparam int         PIN_OUT     = 2;
    localparam logic [2:0] LATCH_RESET = 3'h0;
    localparam logic [2:0] PCTL_RESET  = 3'h7;

    // ==========================================================
    // Bus encodings
    localparam logic       HRESP_OKAY  = 1'b0;

    typedef struct packed {
        logic       unused7;
        logic       on;
        logic       invert;
        logic       result;
        logic [2:0] unused3;
        logic       hyst;
    } ctl_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ahb_req_t;

endpackage
`default_nettype wire

// ---- sync_two_ff.sv ----
// Two-flop synchroniser for the asynchronous comparator output.
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic d,
    output var  logic q
);

    logic meta_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= 1'b0;
            q       <= 1'b0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end

endmodule
`default_nettype wire

// ---- pin_share.sv ----
// Per-pin sharing between ordinary port function and the comparator.
`timescale 1ns/100ps
`default_nettype none
module pin_share #(
    parameter int NP = cmp_pkg::NPINS
) (
    input  wire logic          sel_in,
    input  wire logic          sel_out,
    input  wire logic          result,
    input  wire logic [NP-1:0] latch,
    input  wire logic [NP-1:0] pctl,
    input  wire logic [NP-1:0] pin_in,
    output var  logic [NP-1:0] port_view,
    output var  logic [NP-1:0] pull_en,
    output var  logic [NP-1:0] pin_out,
    output var  logic [NP-1:0] pin_oe
);

    genvar i;
    generate
        for (i = 0; i < NP; i++) begin : g_pin
            logic func_on;
            assign func_on = (i == cmp_pkg::PIN_OUT) ? sel_out : sel_in;
            // With the comparator selected, input mode reads zero, output reads latch.
            assign port_view[i] = func_on ? (pctl[i] ? 1'b0 : latch[i])
                                          : (pctl[i] ? pin_in[i] : latch[i]);
            // Pull-ups are dropped as soon as the comparator owns the pin.
            assign pull_en[i]   = pctl[i] & ~func_on;
            assign pin_out[i]   = (func_on && i == cmp_pkg::PIN_OUT) ? result : latch[i];
            assign pin_oe[i]    = func_on ? (i == cmp_pkg::PIN_OUT) : ~pctl[i];
        end
    endgenerate

endmodule
`default_nettype wire

// ---- comparator_control_logic.sv ----
// Comparator control, status, interrupt and pin sharing with an AHB-Lite slave.
//
// How it works
// - Comparator power output follows comparator_on; off means no power drawn.
// - Clearing comparator_on forces comparator_result low.
// - output_invert selects inverted or plain comparator output for comparator_result.
// - Result bit 4 reads 1 when positive input is higher, swapped if inverted.
// - Hysteresis enable bit 0 controls hysteresis and resets to 1.
// - Control bits 7 and 3 to 1 read zero and ignore writes.
// - Every change of comparator_result, either direction, sets the change flag.
// - Interrupt raised only when flag and its enable are both set.
// - In sleep or idle, an input-driven result change sets flag and wakes; here wake fires only if the flag was clear.
// - An enabled comparator keeps running and flagging during low-power modes.
// - Shared pin data read, with the comparator selected on that pin, gives zero in input mode, latch otherwise.
// - Selecting comparator inputs on a pin disconnects its pull-high resistor.
// - The result can also be driven onto a shared output pin.
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module comparator_control_logic #(
    parameter int NP = cmp_pkg::NPINS
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output var  logic [31:0]   hrdata,
    output var  logic          hreadyout,
    output var  logic          hresp,
    input  wire logic          cmp_raw,
    input  wire logic          low_power,
    output var  logic          cmp_power_on,
    output var  logic          hyst_on,
    output var  logic          wake,
    output var  logic          irq,
    input  wire logic [NP-1:0] pin_in,
    output var  logic [NP-1:0] pin_out,
    output var  logic [NP-1:0] pin_oe,
    output var  logic [NP-1:0] pull_en
);

    // ==========================================================
    // Declarations
    cmp_pkg::ahb_req_t req_ff;
    cmp_pkg::ctl_t     ctl_view;
    logic              on_ff;
    logic              inv_ff;
    logic              hys_ff;
    logic              result_ff;
    logic              nxt_result;
    logic              prev_ff;
    logic              sync_q;
    logic              change;
    logic              stat_ff;
    logic              mask_ff;
    logic              sel_in_ff;
    logic              sel_out_ff;
    logic [NP-1:0]     latch_ff;
    logic [NP-1:0]     pctl_ff;
    logic [NP-1:0]     port_view;
    logic [NP-1:0]     nxt_pull;
    logic [NP-1:0]     nxt_pin_out;
    logic [NP-1:0]     nxt_pin_oe;
    logic [31:0]       rd_value;
    logic              take;
    logic              wr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    // ==========================================================
    // AHB-Lite slave: zero wait states, always OKAY
    assign take = hsel & htrans[1] & hready;
    assign wr   = req_ff.valid & req_ff.write;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_ff <= '0;
        end else if (hready) begin
            req_ff.valid <= take;
            req_ff.write <= hwrite;
            req_ff.addr  <= haddr[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hreadyout <= 1'b1;
            hresp     <= cmp_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= cmp_pkg::HRESP_OKAY;
        end
    end

    always_comb begin
        ctl_view         = '0;
        ctl_view.on      = on_ff;
        ctl_view.invert  = inv_ff;
        ctl_view.result  = result_ff;
        ctl_view.hyst    = hys_ff;
    end

    // Read data is captured in the address phase so it stands for the whole data phase.
    always_comb begin
        rd_value = 32'h0000_0000;
        if (hit(haddr[7:0], cmp_pkg::CTL_OFF)) begin
            rd_value[7:0] = ctl_view;
        end else if (hit(haddr[7:0], cmp_pkg::STAT_OFF)) begin
            rd_value[cmp_pkg::CHG_BIT] = stat_ff;
        end else if (hit(haddr[7:0], cmp_pkg::MASK_OFF)) begin
            rd_value[cmp_pkg::CHG_BIT] = mask_ff;
        end else if (hit(haddr[7:0], cmp_pkg::PINSEL_OFF)) begin
            rd_value[cmp_pkg::SEL_IN_BIT]  = sel_in_ff;
            rd_value[cmp_pkg::SEL_OUT_BIT] = sel_out_ff;
        end else if (hit(haddr[7:0], cmp_pkg::LATCH_OFF)) begin
            rd_value[NP-1:0] = latch_ff;
        end else if (hit(haddr[7:0], cmp_pkg::PCTL_OFF)) begin
            rd_value[NP-1:0] = pctl_ff;
        end else if (hit(haddr[7:0], cmp_pkg::PREAD_OFF)) begin
            rd_value[NP-1:0] = port_view;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= rd_value;
        end
    end

    // ==========================================================
    // Control register; only bits 6, 5 and 0 are writable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            on_ff  <= cmp_pkg::ON_RESET;
            inv_ff <= cmp_pkg::INV_RESET;
            hys_ff <= cmp_pkg::HYS_RESET;
        end else if (wr && hit(req_ff.addr, cmp_pkg::CTL_OFF)) begin
            on_ff  <= hwdata[cmp_pkg::CTL_ON_BIT];
            inv_ff <= hwdata[cmp_pkg::CTL_INV_BIT];
            hys_ff <= hwdata[cmp_pkg::CTL_HYS_BIT];
        end
    end

    // ==========================================================
    // Pin selection, port latch and port direction
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel_in_ff  <= 1'b0;
            sel_out_ff <= 1'b0;
            latch_ff   <= cmp_pkg::LATCH_RESET;
            pctl_ff    <= cmp_pkg::PCTL_RESET;
        end else if (wr) begin
            if (hit(req_ff.addr, cmp_pkg::PINSEL_OFF)) begin
                sel_in_ff  <= hwdata[cmp_pkg::SEL_IN_BIT];
                sel_out_ff <= hwdata[cmp_pkg::SEL_OUT_BIT];
            end
            if (hit(req_ff.addr, cmp_pkg::LATCH_OFF)) begin
                latch_ff <= hwdata[NP-1:0];
            end
            if (hit(req_ff.addr, cmp_pkg::PCTL_OFF)) begin
                pctl_ff <= hwdata[NP-1:0];
            end
        end
    end

    // ==========================================================
    // Result path
    sync_two_ff u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (cmp_raw),
        .q    (sync_q)
    );

    // The low-power input is deliberately not used here: the result keeps updating.
    assign nxt_result = on_ff & (sync_q ^ inv_ff);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            result_ff <= 1'b0;
            prev_ff   <= 1'b0;
        end else begin
            result_ff <= nxt_result;
            prev_ff   <= result_ff;
        end
    end

    assign change = result_ff ^ prev_ff;

    // ==========================================================
    // Change flag, enable and interrupt; a new change wins over a clearing write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_ff <= 1'b0;
        end else begin
            stat_ff <= (stat_ff & ~(wr && hit(req_ff.addr, cmp_pkg::STAT_OFF)
                                    && hwdata[cmp_pkg::CHG_BIT])) | change;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_ff <= 1'b0;
        end else if (wr && hit(req_ff.addr, cmp_pkg::MASK_OFF)) begin
            mask_ff <= hwdata[cmp_pkg::CHG_BIT];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= stat_ff & mask_ff;
        end
    end

    // Wake needs a fresh flag rise, so a flag already set before sleep blocks it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wake <= 1'b0;
        end else begin
            wake <= change & ~stat_ff & low_power & on_ff;
        end
    end

    // ==========================================================
    // Analog controls and shared pins, all registered at the port
    pin_share #(.NP(NP)) u_pins (
        .sel_in    (sel_in_ff),
        .sel_out   (sel_out_ff),
        .result    (result_ff),
        .latch     (latch_ff),
        .pctl      (pctl_ff),
        .pin_in    (pin_in),
        .port_view (port_view),
        .pull_en   (nxt_pull),
        .pin_out   (nxt_pin_out),
        .pin_oe    (nxt_pin_oe)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmp_power_on <= cmp_pkg::ON_RESET;
            hyst_on      <= cmp_pkg::HYS_RESET;
        end else begin
            cmp_power_on <= on_ff;
            hyst_on      <= hys_ff;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pull_en <= cmp_pkg::PCTL_RESET;
            pin_out <= cmp_pkg::LATCH_RESET;
            pin_oe  <= '0;
        end else begin
            pull_en <= nxt_pull;
            pin_out <= nxt_pin_out;
            pin_oe  <= nxt_pin_oe;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence result_moved;
        result_ff != prev_ff;
    endsequence

    sequence moved_in_sleep;
        result_moved ##0 (low_power && on_ff && !stat_ff);
    endsequence

    power_follow_a: assert property (on_ff != cmp_power_on |=> on_ff == cmp_power_on || $changed(on_ff))
        else $error("comparator power does not follow the enable");
    off_low_a: assert property (!on_ff ##1 !on_ff |-> !result_ff)
        else $error("result not low while comparator off");
    polarity_a: assert property (on_ff && $stable(on_ff) |-> result_ff == ($past(sync_q) ^ $past(inv_ff)))
        else $error("result polarity wrong");
    ctl_read_a: assert property (take && !hwrite && hit(haddr[7:0], cmp_pkg::CTL_OFF) |=> hrdata[7] == 1'b0 && hrdata[3:1] == 3'h0 && hrdata[4] == $past(result_ff))
        else $error("control read shows bad reserved or result bits");
    hyst_reset_a: assert property ($rose(rstn) |-> hys_ff)
        else $error("hysteresis not enabled after reset");
    flag_set_a: assert property (result_moved |=> stat_ff)
        else $error("result change did not set flag");
    irq_gate_a: assert property (irq |-> $past(stat_ff) && $past(mask_ff))
        else $error("interrupt without flag and enable");
    wake_on_a: assert property (moved_in_sleep |=> wake && stat_ff)
        else $error("no wake on change during sleep");
    no_wake_a: assert property (stat_ff |=> !wake)
        else $error("wake with flag already set");
    pull_off_a: assert property (sel_in_ff |=> !pull_en[cmp_pkg::PIN_POS] && !pull_en[cmp_pkg::PIN_NEG])
        else $error("pull-up left on for comparator input");
    pin_drive_a: assert property (sel_out_ff && $stable(sel_out_ff) |-> pin_oe[cmp_pkg::PIN_OUT] && pin_out[cmp_pkg::PIN_OUT] == $past(result_ff))
        else $error("result not driven on output pin");
    port_zero_a: assert property (take && !hwrite && hit(haddr[7:0], cmp_pkg::PREAD_OFF) && sel_in_ff && pctl_ff[cmp_pkg::PIN_POS] |=> !hrdata[cmp_pkg::PIN_POS])
        else $error("comparator input pin read not zero");

endmodule
`default_nettype wire

// ---- cmp_core_model.sv ----
// Behavioural model of the analog comparator core that sits behind the control block.
`timescale 1ns/100ps
`default_nettype none
module cmp_core_model #(
    parameter logic [11:0] HYS_MV = 12'h004
) (
    input  wire logic        clk,
    input  wire logic        power_on,
    input  wire logic        hyst_on,
    input  wire logic [11:0] vpos,
    input  wire logic [11:0] vneg,
    output var  logic        cmp_raw
);
    logic [11:0] band;

    // =========================================================
    // Comparison
    // An unpowered core gives no valid output, so it toggles to expose any leak.
    assign band = hyst_on ? HYS_MV : 12'h000;
    initial cmp_raw = 1'b0;
    always @(posedge clk) begin
        if (!power_on) begin
            cmp_raw <= ~cmp_raw;
        end else if (vpos > vneg + band) begin
            cmp_raw <= 1'b1;
        end else if (vpos + band < vneg) begin
            cmp_raw <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- comparator_control_logic_tb.sv ----
// Self-checking testbench for the comparator control block.
`timescale 1ns/100ps
`default_nettype none
module comparator_control_logic_tb;
    logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, low_power = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic        hready, hresp, cmp_raw, cmp_power_on, hyst_on, wake, irq, rd_dp = 1'b0;
    logic [2:0]  pin_in = 3'h0, pin_out, pin_oe, pull_en;
    logic [11:0] vpos = 12'h100, vneg = 12'h200;
    logic [31:0] exp_q[$];
    logic [31:0] rnd = 32'h0000_002a;
    int          fails = 0, total_checks = 0, wakes = 0;

    always #20 clk = ~clk;

    comparator_control_logic u_comparator_control_logic (
        .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .cmp_raw(cmp_raw),
        .low_power(low_power), .cmp_power_on(cmp_power_on), .hyst_on(hyst_on),
        .wake(wake), .irq(irq), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_en(pull_en));

    cmp_core_model u_cmp_core_model (
        .clk(clk), .power_on(cmp_power_on), .hyst_on(hyst_on), .vpos(vpos),
        .vneg(vneg), .cmp_raw(cmp_raw));

    // =========================================================
    // Result watcher: every read data phase takes the oldest note.
    always @(posedge clk) begin
        if (rd_dp && hready === 1'b1) begin
            total_checks++;
            if (hrdata !== exp_q[0]) begin
                fails++;
                $display("Error at %0t: read got %h expected %h", $time, hrdata, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
        rd_dp <= hsel && htrans[1] && hready && !hwrite;
        if (wake === 1'b1) wakes++;
    end

    // =========================================================
    // Helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // A bus idle cycle separates transfers, so no read meets a pending write.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        total_checks++;
        if (got !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    task automatic settle;
        repeat (8) @(posedge clk);
    endtask

    task automatic final_report;
        $display("Checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #(40 * 6000);
        fails++;
        final_report;
    end

    // =========================================================
    // Main sequence
    initial begin
        logic hi, inv;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd(cmp_pkg::CTL_OFF, 32'h01);
        rd(cmp_pkg::STAT_OFF, 32'h0);
        rd(cmp_pkg::PCTL_OFF, 32'h7);
        rd(8'h1c, 32'h0);
        chk({hresp, hyst_on, cmp_power_on}, 3'b010);
        $display("Reset values done");
        for (int i = 0; i < 4; i++) begin
            {hi, inv} = i[1:0];
            vpos <= hi ? 12'h300 : 12'h100;
            wr(cmp_pkg::CTL_OFF, {24'h0, 2'b11, inv, 5'h1f});
            settle;
            rd(cmp_pkg::CTL_OFF, {24'h0, 2'b01, inv, hi ^ inv, 4'h1});
            wr(cmp_pkg::STAT_OFF, 32'h1);
        end
        $display("Polarity done");
        wr(cmp_pkg::CTL_OFF, 32'h41);
        vpos <= 12'h100;
        settle;
        wr(cmp_pkg::STAT_OFF, 32'h1);
        wr(cmp_pkg::MASK_OFF, 32'h1);
        chk(irq, 1'b0);
        vpos <= 12'h300;
        settle;
        chk(irq, 1'b1);
        rd(cmp_pkg::STAT_OFF, 32'h1);
        wr(cmp_pkg::STAT_OFF, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr(cmp_pkg::MASK_OFF, 32'h0);
        vpos <= 12'h100;
        settle;
        rd(cmp_pkg::STAT_OFF, 32'h1);
        chk(irq, 1'b0);
        $display("Interrupt done");
        vpos <= 12'h300;
        settle;
        wr(cmp_pkg::STAT_OFF, 32'h1);
        wr(cmp_pkg::CTL_OFF, 32'h01);
        settle;
        rd(cmp_pkg::CTL_OFF, 32'h01);
        rd(cmp_pkg::STAT_OFF, 32'h1);
        chk(cmp_power_on, 1'b0);
        wr(cmp_pkg::CTL_OFF, 32'h00);
        repeat (2) @(posedge clk);
        chk(hyst_on, 1'b0);
        $display("Power off done");
        vpos <= 12'h100;
        wr(cmp_pkg::CTL_OFF, 32'h41);
        settle;
        wr(cmp_pkg::STAT_OFF, 32'h1);
        low_power <= 1'b1;
        vpos <= 12'h300;
        settle;
        chk(wakes, 1);
        rd(cmp_pkg::CTL_OFF, 32'h51);
        vpos <= 12'h100;
        settle;
        chk(wakes, 1);
        low_power <= 1'b0;
        wr(cmp_pkg::CTL_OFF, 32'h01);
        $display("Sleep done");
        rnd = xorshift(rnd);
        pin_in <= rnd[2:0];
        wr(cmp_pkg::LATCH_OFF, {29'h0, rnd[5:3]});
        wr(cmp_pkg::PINSEL_OFF, 32'h1);
        repeat (2) @(posedge clk);
        chk(pull_en[1:0], 2'b00);
        rd(cmp_pkg::PREAD_OFF, {29'h0, rnd[2], 2'b00});
        wr(cmp_pkg::PCTL_OFF, 32'h0);
        rd(cmp_pkg::PREAD_OFF, {29'h0, rnd[5:3]});
        vpos <= 12'h300;
        wr(cmp_pkg::PINSEL_OFF, 32'h2);
        wr(cmp_pkg::CTL_OFF, 32'h41);
        settle;
        chk({pin_oe[2], pin_out[2]}, 2'b11);
        chk({pin_oe, pin_out[1:0], pull_en}, {3'b111, rnd[4:3], 3'b000});
        $display("Pins done");
        final_report;
    end
endmodule
`default_nettype wire
